// ### pbf_defines.svh
`ifndef PBF_DEFINES_SVH
`define PBF_DEFINES_SVH

// Register byte offsets on the APB window
`define PBF_OFF_DIRECTION     12'h000
`define PBF_OFF_FSEL_HIGH     12'h004
`define PBF_OFF_FSEL_LOW      12'h008

// Register reset values
`define PBF_RST_DIRECTION     16'h0000
`define PBF_RST_FSEL_HIGH     16'h0000
`define PBF_RST_FSEL_LOW      16'h0000

// Implemented bits; all others read as zero
`define PBF_MASK_DIRECTION    16'h3FFF
`define PBF_MASK_FSEL_HIGH    16'h0555
`define PBF_MASK_FSEL_LOW     16'h5555

// Field positions in the high function-select register
`define PBF_POS_PIN13_SEL     10
`define PBF_POS_PIN12_SEL     8
`define PBF_POS_PIN11_SEL     6
`define PBF_POS_PIN10_SEL     4
`define PBF_POS_PIN9_SEL      2
`define PBF_POS_PIN8_SEL      0

// Field positions in the low function-select register
`define PBF_POS_PIN7_SEL      14
`define PBF_POS_PIN6_SEL      12
`define PBF_POS_PIN5_SEL      10
`define PBF_POS_PIN4_SEL      8
`define PBF_POS_PIN3_SEL      6
`define PBF_POS_PIN2_SEL      4
`define PBF_POS_PIN1_SEL      2
`define PBF_POS_PIN0_SEL      0

// Pins whose controller function is an input
`define PBF_PERIPH_INPUT_PINS 14'h0003

// Level driven to the controller while its input pin is not selected
`define PBF_PERIPH_IN_IDLE    1'b1

`endif

// ### pbf_pkg.sv
package pbf_pkg;

    // Which register an APB address selects
    typedef enum logic [1:0] {
        PBF_SEL_DIRECTION,
        PBF_SEL_FSEL_HIGH,
        PBF_SEL_FSEL_LOW,
        PBF_SEL_NONE
    } pbf_reg_sel_t;

    // APB slave phase
    typedef enum logic [1:0] {
        PBF_IDLE,
        PBF_WAIT,
        PBF_DONE
    } pbf_apb_state_t;

    typedef logic [15:0] pbf_word_t;
    typedef logic [13:0] pbf_pins_t;

endpackage : pbf_pkg

// ### pbf_masked_reg.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbf_defines.svh"

module pbf_masked_reg
    import pbf_pkg::*;
#(
    parameter pbf_word_t RESET_VALUE = 16'h0000,
    parameter pbf_word_t WRITE_MASK  = 16'hFFFF
) (
    input  wire logic      clk_sys,
    input  wire logic      rst_b,
    input  wire logic      wr_en,
    input  wire pbf_word_t wr_data,
    output var  pbf_word_t value
);

    pbf_word_t value_reg;

    // Reserved bits never store a one, so they always read as zero
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            value_reg <= RESET_VALUE & WRITE_MASK;
        end else if (wr_en) begin
            value_reg <= wr_data & WRITE_MASK;
        end
    end

    assign value = value_reg;

endmodule : pbf_masked_reg
`default_nettype wire

// ### pbf_pin_cell.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbf_defines.svh"

module pbf_pin_cell #(
    parameter bit PERIPH_IS_INPUT = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic func_sel,
    input  wire logic dir_bit,
    input  wire logic port_out,
    input  wire logic periph_out,
    input  wire logic pad_in,
    output var  logic pad_out,
    output var  logic pad_oe_b,
    output var  logic port_in,
    output var  logic periph_in
);

    logic pad_out_reg;
    logic pad_oe_b_reg;
    logic port_in_reg;
    logic periph_in_reg;
    logic drive_next;

    // Pad direction: controller function decides, else the direction bit
    always_comb begin
        if (func_sel) begin
            drive_next = !PERIPH_IS_INPUT;
        end else begin
            drive_next = dir_bit;
        end
    end

    // Pad driver and captured pad levels
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pad_out_reg   <= 1'b0;
            pad_oe_b_reg  <= 1'b1;
            port_in_reg   <= 1'b0;
            periph_in_reg <= `PBF_PERIPH_IN_IDLE;
        end else begin
            pad_out_reg   <= func_sel ? periph_out : port_out;
            pad_oe_b_reg  <= !drive_next;
            port_in_reg   <= pad_in;
            periph_in_reg <= (func_sel && PERIPH_IS_INPUT) ? pad_in : `PBF_PERIPH_IN_IDLE;
        end
    end

    assign pad_out   = pad_out_reg;
    assign pad_oe_b  = pad_oe_b_reg;
    assign port_in   = port_in_reg;
    assign periph_in = periph_in_reg;

endmodule : pbf_pin_cell
`default_nettype wire

// ### pbf_port_b_ctrl.sv
// Function
// - Direction one drives pin, zero inputs
// - Bits 13..0 map pins; GPIO only
// - Direction bits 15,14 read zero
// - Direction resets to all zeros
// - Two 16-bit readable writable select registers
// - High select 15..11 and odd bits zero
// - High bit 10 selects bus start
// - High bit 8 selects area-3 select
// - High bit 6 selects area-4 select
// - High bit 4 selects area-5b/card-1a
// - High bit 2 selects card enable 2a
// - High bit 0 selects area-6b/card-1b
// - Low select bit 15, odd bits zero
// - Low bit 14 selects card enable 2b
// - Low bit 12 selects byte-3 strobe
// - Low bit 10 selects byte-2 strobe
// - Low bit 8 selects row strobe
// - Low bit 6 selects column strobe
// - Low bit 4 selects clock enable
// - Low bit 2 selects 16-bit indicator
// - Low bit 0 selects wait request
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "pbf_defines.svh"

module pbf_port_b_ctrl
    import pbf_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Pads
    input  wire pbf_pins_t   pad_in,
    output var  pbf_pins_t   pad_out,
    output var  pbf_pins_t   pad_oe_b,
    // General port side
    input  wire pbf_pins_t   port_out,
    output var  pbf_pins_t   port_in,
    // Bus state controller outputs toward the pads
    input  wire logic        bus_start_strobe,
    input  wire logic        chip_select_area3,
    input  wire logic        chip_select_area4,
    input  wire logic        chip_select_area5b_card_enable_1a,
    input  wire logic        card_enable_2a,
    input  wire logic        chip_select_area6b_card_enable_1b,
    input  wire logic        card_enable_2b,
    input  wire logic        byte3_write_strobe_shared,
    input  wire logic        byte2_write_strobe_shared,
    input  wire logic        dram_row_strobe,
    input  wire logic        dram_column_strobe,
    input  wire logic        sdram_clock_enable,
    // Bus state controller inputs from the pads
    output var  logic        io_card_16bit_indicator,
    output var  logic        bus_wait_request,
    // Pin function status
    output var  pbf_pins_t   pin_controller_owned
);

    // Address decode, shared by read and write paths
    function automatic pbf_reg_sel_t pbf_decode(input logic [11:0] addr);
        unique case (addr)
            `PBF_OFF_DIRECTION: pbf_decode = PBF_SEL_DIRECTION;
            `PBF_OFF_FSEL_HIGH: pbf_decode = PBF_SEL_FSEL_HIGH;
            `PBF_OFF_FSEL_LOW:  pbf_decode = PBF_SEL_FSEL_LOW;
            default:            pbf_decode = PBF_SEL_NONE;
        endcase
    endfunction : pbf_decode

    pbf_apb_state_t state_reg;
    pbf_apb_state_t state_next;
    logic [31:0]    prdata_reg;
    logic           pready_reg;
    logic           pslverr_reg;
    pbf_pins_t      owned_reg;

    pbf_reg_sel_t   sel_now;
    logic           access_done;
    logic           wr_direction;
    logic           wr_fsel_high;
    logic           wr_fsel_low;
    pbf_word_t      direction;
    pbf_word_t      fsel_high;
    pbf_word_t      fsel_low;
    pbf_word_t      rd_word;
    pbf_pins_t      func_sel;
    pbf_pins_t      periph_out;
    pbf_pins_t      periph_in;

    // Decode of the address held through the transfer
    assign sel_now = pbf_decode(paddr);

    // Transfer completes at the edge where pready is seen high
    assign access_done = psel && penable && pready_reg;

    // APB phase sequencing: one wait cycle, then ready for one cycle
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PBF_IDLE: begin
                if (psel && !penable) begin
                    state_next = PBF_WAIT;
                end
            end
            PBF_WAIT: begin
                if (psel && penable) begin
                    state_next = PBF_DONE;
                end
            end
            PBF_DONE: begin
                state_next = PBF_IDLE;
            end
            default: begin
                state_next = PBF_IDLE;
            end
        endcase
    end

    // Phase register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg <= PBF_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Ready flag, high only in the cycle of completion
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= (state_next == PBF_DONE);
        end
    end

    // Write strobes, taken only at the completing edge
    assign wr_direction = access_done && pwrite && (sel_now == PBF_SEL_DIRECTION);
    assign wr_fsel_high = access_done && pwrite && (sel_now == PBF_SEL_FSEL_HIGH);
    assign wr_fsel_low  = access_done && pwrite && (sel_now == PBF_SEL_FSEL_LOW);

    // Direction register; top two bits are not stored
    pbf_masked_reg #(
        .RESET_VALUE (`PBF_RST_DIRECTION),
        .WRITE_MASK  (`PBF_MASK_DIRECTION)
    ) u_direction (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr_en   (wr_direction),
        .wr_data (pwdata[15:0]),
        .value   (direction)
    );

    // High function-select register
    pbf_masked_reg #(
        .RESET_VALUE (`PBF_RST_FSEL_HIGH),
        .WRITE_MASK  (`PBF_MASK_FSEL_HIGH)
    ) u_fsel_high (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr_en   (wr_fsel_high),
        .wr_data (pwdata[15:0]),
        .value   (fsel_high)
    );

    // Low function-select register
    pbf_masked_reg #(
        .RESET_VALUE (`PBF_RST_FSEL_LOW),
        .WRITE_MASK  (`PBF_MASK_FSEL_LOW)
    ) u_fsel_low (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr_en   (wr_fsel_low),
        .wr_data (pwdata[15:0]),
        .value   (fsel_low)
    );

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_word = 16'h0000;
        unique case (sel_now)
            PBF_SEL_DIRECTION: rd_word = direction;
            PBF_SEL_FSEL_HIGH: rd_word = fsel_high;
            PBF_SEL_FSEL_LOW:  rd_word = fsel_low;
            PBF_SEL_NONE:      rd_word = 16'h0000;
        endcase
    end

    // Read data and error answer, held with pready
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (state_next == PBF_DONE) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
            pslverr_reg <= (sel_now == PBF_SEL_NONE);
        end else begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
    end

    // Per-pin function choice, one field per multiplexed pin
    assign func_sel[13] = fsel_high[`PBF_POS_PIN13_SEL];
    assign func_sel[12] = fsel_high[`PBF_POS_PIN12_SEL];
    assign func_sel[11] = fsel_high[`PBF_POS_PIN11_SEL];
    assign func_sel[10] = fsel_high[`PBF_POS_PIN10_SEL];
    assign func_sel[9]  = fsel_high[`PBF_POS_PIN9_SEL];
    assign func_sel[8]  = fsel_high[`PBF_POS_PIN8_SEL];
    assign func_sel[7]  = fsel_low[`PBF_POS_PIN7_SEL];
    assign func_sel[6]  = fsel_low[`PBF_POS_PIN6_SEL];
    assign func_sel[5]  = fsel_low[`PBF_POS_PIN5_SEL];
    assign func_sel[4]  = fsel_low[`PBF_POS_PIN4_SEL];
    assign func_sel[3]  = fsel_low[`PBF_POS_PIN3_SEL];
    assign func_sel[2]  = fsel_low[`PBF_POS_PIN2_SEL];
    assign func_sel[1]  = fsel_low[`PBF_POS_PIN1_SEL];
    assign func_sel[0]  = fsel_low[`PBF_POS_PIN0_SEL];

    // Controller signals gathered by pin number
    assign periph_out[13] = bus_start_strobe;
    assign periph_out[12] = chip_select_area3;
    assign periph_out[11] = chip_select_area4;
    assign periph_out[10] = chip_select_area5b_card_enable_1a;
    assign periph_out[9]  = card_enable_2a;
    assign periph_out[8]  = chip_select_area6b_card_enable_1b;
    assign periph_out[7]  = card_enable_2b;
    assign periph_out[6]  = byte3_write_strobe_shared;
    assign periph_out[5]  = byte2_write_strobe_shared;
    assign periph_out[4]  = dram_row_strobe;
    assign periph_out[3]  = dram_column_strobe;
    assign periph_out[2]  = sdram_clock_enable;
    assign periph_out[1]  = 1'b0;                               // Input-only function
    assign periph_out[0]  = 1'b0;                               // Input-only function

    // One pad cell per pin; direction bit k steers pin k
    for (genvar k = 0; k < 14; k++) begin : g_pin
        pbf_pin_cell #(
            .PERIPH_IS_INPUT (1'((`PBF_PERIPH_INPUT_PINS >> k) & 14'h0001))
        ) u_cell (
            .clk_sys    (clk_sys),
            .rst_b      (rst_b),
            .func_sel   (func_sel[k]),
            .dir_bit    (direction[k]),
            .port_out   (port_out[k]),
            .periph_out (periph_out[k]),
            .pad_in     (pad_in[k]),
            .pad_out    (pad_out[k]),
            .pad_oe_b   (pad_oe_b[k]),
            .port_in    (port_in[k]),
            .periph_in  (periph_in[k])
        );
    end

    // Controller inputs taken from their pins when selected
    assign io_card_16bit_indicator = periph_in[1];
    assign bus_wait_request        = periph_in[0];

    // Status of which pins the controller owns
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            owned_reg <= 14'h0000;
        end else begin
            owned_reg <= func_sel;
        end
    end

    assign prdata               = prdata_reg;
    assign pready               = pready_reg;
    assign pslverr              = pslverr_reg;
    assign pin_controller_owned = owned_reg;

endmodule : pbf_port_b_ctrl
`default_nettype wire

// ### pbf_port_b_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module pbf_port_b_ctrl_asserts
    import pbf_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire pbf_pins_t   pad_in,
    input wire pbf_pins_t   pad_out,
    input wire pbf_pins_t   pad_oe_b,
    input wire pbf_pins_t   port_out,
    input wire logic        bus_start_strobe,
    input wire logic        io_card_16bit_indicator,
    input wire logic        bus_wait_request,
    input wire pbf_pins_t   pin_controller_owned
);
    pbf_pins_t own;
    assign own = pin_controller_owned;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // First access cycle, answer still pending
    sequence s_access;
        psel && penable && !pready;
    endsequence
    // Completed read of one register
    sequence s_read(logic [11:0] a);
        pready && !pwrite && paddr == a;
    endsequence
    a_one_wait_state: assert property (s_access |=> pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_unmapped: assert property (pready |->
        pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
        else $error("pslverr wrong for address");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    a_dir_rsvd: assert property (s_read(12'h000) |-> prdata[31:14] == 18'h0)
        else $error("direction reserved bits set");
    a_high_rsvd: assert property (s_read(12'h004) |-> (prdata & 32'hFFFF_FAAA) == 0)
        else $error("high select reserved bits set");
    a_low_rsvd: assert property (s_read(12'h008) |-> (prdata & 32'hFFFF_AAAA) == 0)
        else $error("low select reserved bits set");
    a_reset_inputs: assert property ($rose(rst_b) |-> pad_oe_b == 14'h3FFF && own == 0)
        else $error("pins not inputs after reset");
    a_owned_out_dir: assert property ($stable(own) |-> (pad_oe_b[13:2] & own[13:2]) == 0)
        else $error("controller output pin not driven");
    a_owned_in_dir: assert property ($stable(own) |-> (~pad_oe_b[1:0] & own[1:0]) == 0)
        else $error("controller input pin driven");
    a_strobe_pass: assert property ($stable(own) && own[13] |->
        pad_out[13] == $past(bus_start_strobe)) else $error("strobe not on pin 13");
    a_port_pass: assert property ($stable(own) |->
        ((pad_out ^ $past(port_out)) & ~pad_oe_b & ~own) == 0) else $error("port value lost");
    a_ctrl_inputs: assert property ($stable(own) |-> {io_card_16bit_indicator,
        bus_wait_request} == (~own[1:0] | (own[1:0] & $past(pad_in[1:0]))))
        else $error("controller input wrong");
endmodule : pbf_port_b_ctrl_asserts
bind pbf_port_b_ctrl pbf_port_b_ctrl_asserts pbf_port_b_ctrl_asserts_i (
    .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .pad_in, .pad_out, .pad_oe_b, .port_out, .bus_start_strobe, .io_card_16bit_indicator,
    .bus_wait_request, .pin_controller_owned
);
`default_nettype wire

// ### pbf_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
module pbf_pad_model
    import pbf_pkg::*;
(
    input  wire pbf_pins_t   ext,
    input  wire logic [11:0] ctrl,
    input  wire pbf_pins_t   pad_out,
    input  wire pbf_pins_t   pad_oe_b,
    output var  pbf_pins_t   pad_in,
    output var  logic [11:0] strobes
);
    // Controller strobes toward pins 13..2
    always_comb begin
        strobes = ctrl;
    end
    // Pad level: device wins where it drives, board level elsewhere
    always_comb begin
        pad_in = (pad_oe_b & ext) | (~pad_oe_b & pad_out);
    end
endmodule : pbf_pad_model
`default_nettype wire

// ### tb_pbf_port_b_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_pbf_port_b_ctrl
    import pbf_pkg::*;
;
    logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, e;
    logic        io_card_16bit_indicator, bus_wait_request;
    logic [11:0] paddr, ctrl, strb;
    logic [31:0] pwdata, prdata, r, d;
    pbf_pins_t   pad_in, pad_out, pad_oe_b, port_out, port_in, ext, pin_controller_owned;
    pbf_word_t   rg [3];
    pbf_word_t   msk [3] = '{16'h3FFF, 16'h0555, 16'h5555};
    int          miscompares, comparisons, a;

    pbf_port_b_ctrl pbf_port_b_ctrl_i (
        .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pad_in, .pad_out, .pad_oe_b, .port_out, .port_in,
        .bus_start_strobe(strb[11]), .chip_select_area3(strb[10]),
        .chip_select_area4(strb[9]), .chip_select_area5b_card_enable_1a(strb[8]),
        .card_enable_2a(strb[7]), .chip_select_area6b_card_enable_1b(strb[6]),
        .card_enable_2b(strb[5]), .byte3_write_strobe_shared(strb[4]),
        .byte2_write_strobe_shared(strb[3]), .dram_row_strobe(strb[2]),
        .dram_column_strobe(strb[1]), .sdram_clock_enable(strb[0]),
        .io_card_16bit_indicator, .bus_wait_request, .pin_controller_owned
    );
    pbf_pad_model pbf_pad_model_i (.ext, .ctrl, .pad_out, .pad_oe_b, .pad_in, .strobes(strb));

    // Clock, 25 ns period
    initial begin
        clk_sys = 0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; psel stays up for a back-to-back successor
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1;
        for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge clk_sys);
        if (n == 16) begin
            chk(0, 1);
            stop_test();
        end
        r = prdata;
        e = pslverr;
        penable <= 0;
    endtask : apb

    // Pin select vector from both select registers
    function automatic pbf_pins_t sel_of(pbf_word_t h, pbf_word_t l);
        return {h[10], h[8], h[6], h[4], h[2], h[0],
                l[14], l[12], l[10], l[8], l[6], l[4], l[2], l[0]};
    endfunction : sel_of

    // Let pin stimulus settle, then compare every pad path
    task automatic pins();
        pbf_pins_t s, ob, o;
        repeat (4) @(posedge clk_sys);
        s  = sel_of(rg[1], rg[2]);
        ob = (s & 14'h0003) | (~s & ~rg[0][13:0]);
        o  = (s & {ctrl, 2'b00}) | (~s & port_out);
        chk(pad_oe_b, ob);
        chk(pad_out & ~ob, o & ~ob);
        chk(port_in, (ob & ext) | (~ob & o));
        chk(pin_controller_owned, s);
        chk({io_card_16bit_indicator, bus_wait_request}, 2'(~s[1:0] | (s & ext)));
    endtask : pins

    initial begin
        rst_b = 0;
        {psel, penable, pwrite, paddr, pwdata, port_out, ctrl, ext} = '0;
        rg = '{16'h0000, 16'h0000, 16'h0000};
        void'($urandom(60805));
        repeat (8) @(posedge clk_sys);
        rst_b <= 1;
        @(posedge clk_sys);
        chk(pad_oe_b, 14'h3FFF);
        // Reset values, then all implemented ones, all zeros, then random legal words
        for (int k = 0; k < 45; k++) begin
            a = (k < 9) ? k % 3 : $urandom_range(2);
            d = (k < 6) ? {16'h0, msk[a]} : (k < 9) ? 32'h0 : $urandom & msk[a];
            apb(0, 12'(4 * a), 32'h0);
            chk(r, {16'h0, rg[a]});
            apb(1, 12'(4 * a), d);
            chk(e, 0);
            rg[a] = d[15:0] & msk[a];
            apb(0, 12'(4 * a), 32'h0);
            chk(r, {16'h0, rg[a]});
            psel <= 0;
            port_out <= 14'($urandom);
            ctrl <= 12'($urandom);
            ext <= 14'($urandom);
            pins();
        end
        // Unmapped and unaligned addresses: write dropped, read zero with error
        apb(1, 12'h00C, 32'hFFFF_FFFF);
        chk(e, 1);
        apb(0, 12'h00C, 32'h0);
        chk(e, 1);
        chk(r, 0);
        apb(0, 12'h002, 32'h0);
        chk(e, 1);
        chk(r, 0);
        for (int i = 0; i < 3; i++) begin
            apb(0, 12'(4 * i), 32'h0);
            chk(r, {16'h0, rg[i]});
        end
        psel <= 0;
        pins();
        // Mid-run reset: registers and pins return to their reset state
        rst_b <= 0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1;
        @(posedge clk_sys);
        chk(pad_oe_b, 14'h3FFF);
        rg = '{16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            apb(0, 12'(4 * i), 32'h0);
            chk(r, {16'h0, rg[i]});
        end
        psel <= 0;
        pins();
        stop_test();
    end
endmodule : tb_pbf_port_b_ctrl
`default_nettype wire
